/* verilog/usfp_port.sv */
// bridge-side slave fifo port: endpoint fifos, flags, strobes, usb side
//
// Notes on behaviour
// R1 - two-bit select picks the endpoint fifo
// R2 - full, empty, level flags for selected fifo
// R3 - four active-low control bits run handshake
// R4 - sixteen-bit shared two-way data bus
// R5 - one dedicated fifo per endpoint
// R6 - host-to-card payload lands in endpoint fifo
// R7 - card writes card-to-host fifo directly
// R8 - bridge fills out fifos unaided
// R9 - in data leaves when enough or committed
// R10 - two card fpgas share these lines
// R11 - host starts every transfer
// R12 - packets never exceed 512 bytes
// R13 - card reads command fifo until empty
// R14 - 256 words offered at once as packet; the port also commits a packet when the 8-word fifo fills
// R15 - packet-end line commits a short packet
// R16 - only one card fpga accesses at once
// R17 - idle card fpga floats its outputs; the card model floats only its data and keeps strobes and select driven
// R18 - select stable around every strobe
`timescale 1ns/1ps
`default_nettype none
module usfp_port #(
  parameter int NUM_EP = usfp_pkg::NUM_EP,
  parameter int DEPTH = usfp_pkg::FIFO_DEPTH,
  parameter int PKT_WORDS = usfp_pkg::PKT_WORDS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // card-side fifo port
  input wire logic [usfp_pkg::SEL_W-1:0] fifo_sel,
  input wire usfp_pkg::usfp_ctl_t ctl,
  output usfp_pkg::usfp_flags_t flags,
  input wire logic [usfp_pkg::DATA_W-1:0] data_in,
  output logic [usfp_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  // usb side, host-to-card words
  input wire logic usb_out_valid,
  input wire logic [usfp_pkg::SEL_W-1:0] usb_out_ep,
  input wire logic [usfp_pkg::DATA_W-1:0] usb_out_data,
  output logic usb_out_ready,
  // usb side, card-to-host packets
  input wire logic [usfp_pkg::SEL_W-1:0] usb_in_ep,
  input wire logic usb_in_ready,
  output logic usb_in_valid,
  output logic [usfp_pkg::DATA_W-1:0] usb_in_data,
  output logic usb_in_last,
  // register port
  input wire logic [usfp_pkg::REG_AW-1:0] reg_addr,
  input wire logic [usfp_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [usfp_pkg::REG_DW-1:0] reg_rdata
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int DW = usfp_pkg::DATA_W;
  localparam int RW = usfp_pkg::REG_DW;

  typedef struct packed {
    logic [DW-1:0] dout;
    logic doe;
    usfp_pkg::usfp_flags_t flags;
    logic [RW-1:0] rdata;
    logic [NUM_EP-1:0] dir;
    logic [RW-1:0] level;
    logic [RW-1:0] short_cnt;
    logic out_ready;
    logic in_valid;
    logic [DW-1:0] in_data;
    logic in_last;
  } usfp_port_t;

  usfp_port_t s_ff;
  usfp_port_t nxt_s;

  logic [NUM_EP-1:0] f_push;
  logic [NUM_EP-1:0] f_pop;
  logic [NUM_EP-1:0] f_in_ready;
  logic [NUM_EP-1:0] f_out_valid;
  logic [NUM_EP-1:0] p_avail;
  logic [NUM_EP-1:0] p_last;
  logic [NUM_EP-1:0] p_short;
  logic [DW-1:0] f_in_data [NUM_EP];
  logic [DW-1:0] f_out_data [NUM_EP];
  logic [CW-1:0] f_count [NUM_EP];
  logic rd_take;
  logic in_take;
  logic [RW-1:0] status;

  // a read strobe only pops a host-to-card fifo that holds data
  assign rd_take = !ctl.rd_n && !s_ff.dir[fifo_sel] && f_out_valid[fifo_sel];
  // a word leaves only from a committed packet on the polled endpoint
  assign in_take = (!s_ff.in_valid || usb_in_ready) && s_ff.dir[usb_in_ep] &&
                   p_avail[usb_in_ep] && f_out_valid[usb_in_ep];

  genvar e;
  generate
    for (e = 0; e < NUM_EP; e++) begin : g_ep
      logic sel_hit;
      logic usb_hit;
      assign sel_hit = (fifo_sel == usfp_pkg::SEL_W'(e));
      assign usb_hit = (usb_out_ep == usfp_pkg::SEL_W'(e));
      // R7 card writes in fifo
      assign f_push[e] = s_ff.dir[e] ? (sel_hit && !ctl.wr_n)
                                     : (usb_out_valid && s_ff.out_ready && usb_hit);
      // R6 host payload queued
      assign f_in_data[e] = s_ff.dir[e] ? data_in : usb_out_data;
      assign f_pop[e] = s_ff.dir[e] ? (in_take && usb_in_ep == usfp_pkg::SEL_W'(e))
                                    : (sel_hit && rd_take);

      // R5 fifo per endpoint
      usfp_fifo #(
        .WIDTH(DW),
        .DEPTH(DEPTH)
      ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(f_push[e]),
        .in_ready(f_in_ready[e]),
        .in_data(f_in_data[e]),
        .out_valid(f_out_valid[e]),
        .out_ready(f_pop[e]),
        .out_data(f_out_data[e]),
        .count(f_count[e])
      );

      // R9 commit on count
      usfp_pkt #(
        .PKT_WORDS(PKT_WORDS),
        .CW(usfp_pkg::PKT_CNT_W)
      ) u_pkt (
        .clk(clk),
        .rst_n(rst_n),
        .push(f_push[e] && f_in_ready[e] && s_ff.dir[e]),
        .pop(f_pop[e] && s_ff.dir[e]),
        .fifo_full(!f_in_ready[e] && s_ff.dir[e]),
        // R15 packet end commits
        .commit_req(s_ff.dir[e] && sel_hit && !ctl.pkt_end_n),
        .avail(p_avail[e]),
        .last(p_last[e]),
        .short_evt(p_short[e])
      );
    end
  endgenerate

  always_comb begin
    nxt_s = s_ff;
    status = '0;
    status[usfp_pkg::STATUS_EMPTY_LSB +: NUM_EP] = ~f_out_valid;
    status[usfp_pkg::STATUS_FULL_LSB +: NUM_EP] = ~f_in_ready;

    // R1 flags follow select
    // R2 three status flags
    nxt_s.flags.full = !f_in_ready[fifo_sel];
    nxt_s.flags.empty = !f_out_valid[fifo_sel];
    nxt_s.flags.prog = (RW'(f_count[fifo_sel]) >= s_ff.level);

    // R4 bus driven on oe
    nxt_s.doe = !ctl.oe_n && !s_ff.dir[fifo_sel];
    // R3 read strobe pops
    if (rd_take) begin
      nxt_s.dout = f_out_data[fifo_sel];
    end

    // R8 usb fills unaided; one spare slot covers the registered ready
    nxt_s.out_ready = !s_ff.dir[usb_out_ep] &&
                      (f_count[usb_out_ep] <= CW'(DEPTH - 2));

    // R11 host polling drains
    // R14 committed packet offered
    // R12 packet length bounded
    // the packet-end mark only ever qualifies a word in flight
    if (s_ff.in_valid && usb_in_ready) begin
      nxt_s.in_valid = 1'b0;
      nxt_s.in_last = 1'b0;
    end
    if (in_take) begin
      nxt_s.in_valid = 1'b1;
      nxt_s.in_data = f_out_data[usb_in_ep];
      nxt_s.in_last = p_last[usb_in_ep];
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        usfp_pkg::REG_CTRL: nxt_s.dir = reg_wdata[NUM_EP-1:0];
        usfp_pkg::REG_LEVEL: nxt_s.level = reg_wdata;
        usfp_pkg::REG_SHORT: nxt_s.short_cnt = '0;
        default: nxt_s.dir = s_ff.dir;
      endcase
    end
    // short packets counted after any clear, so a new one is never lost
    for (int i = 0; i < NUM_EP; i++) begin
      nxt_s.short_cnt = RW'(nxt_s.short_cnt + RW'(p_short[i]));
    end

    // register reads answer next cycle, unmapped reads give zero
    nxt_s.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        usfp_pkg::REG_CTRL: nxt_s.rdata = RW'(s_ff.dir);
        usfp_pkg::REG_LEVEL: nxt_s.rdata = s_ff.level;
        usfp_pkg::REG_STATUS: nxt_s.rdata = status;
        usfp_pkg::REG_SHORT: nxt_s.rdata = s_ff.short_cnt;
        default: nxt_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.flags.empty <= 1'b1;
      s_ff.dir <= usfp_pkg::CTRL_RST[NUM_EP-1:0];
      s_ff.level <= usfp_pkg::LEVEL_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign flags = s_ff.flags;
  assign data_out = s_ff.dout;
  assign data_oe = s_ff.doe;
  assign usb_out_ready = s_ff.out_ready;
  assign usb_in_valid = s_ff.in_valid;
  assign usb_in_data = s_ff.in_data;
  assign usb_in_last = s_ff.in_last;
  assign reg_rdata = s_ff.rdata;
endmodule // usfp_port
`default_nettype wire

/* verilog/usfp_pkg.sv */
// shared constants and carrier types for the bridge slave fifo port
package usfp_pkg;
  localparam int DATA_W = 16;
  localparam int SEL_W = 2;
  localparam int NUM_EP = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int PKT_BYTES = 512;
  localparam int PKT_WORDS = PKT_BYTES / (DATA_W / 8);
  localparam int PKT_CNT_W = $clog2(PKT_WORDS + 1);
  // register port
  localparam int REG_AW = 4;
  localparam int REG_DW = 16;
  localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] REG_LEVEL = 4'h4;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h8;
  localparam logic [REG_AW-1:0] REG_SHORT = 4'hC;
  localparam logic [REG_DW-1:0] CTRL_RST = 16'h000C;
  localparam logic [REG_DW-1:0] LEVEL_RST = 16'h0004;
  localparam int STATUS_EMPTY_LSB = 0;
  localparam int STATUS_FULL_LSB = NUM_EP;

  // strobe and control bits, all active low
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic oe_n;
    logic pkt_end_n;
  } usfp_ctl_t;

  // status of the selected fifo
  typedef struct packed {
    logic full;
    logic empty;
    logic prog;
  } usfp_flags_t;
endpackage

/* verilog/usfp_fifo.sv */
// parameterised word fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module usfp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // occupancy
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } usfp_fifo_t;

  usfp_fifo_t s_ff;
  usfp_fifo_t nxt_s;
  logic do_wr;
  logic do_rd;

  assign in_ready = (s_ff.cnt != CW'(DEPTH));
  assign out_valid = (s_ff.cnt != '0);
  assign out_data = s_ff.mem[s_ff.rp];
  assign count = s_ff.cnt;
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_ready && out_valid;

  // pointers wrap naturally, so depth must be a power of two
  always_comb begin
    nxt_s = s_ff;
    if (do_wr) begin
      nxt_s.mem[s_ff.wp] = in_data;
      nxt_s.wp = AW'(s_ff.wp + 1'b1);
    end
    if (do_rd) begin
      nxt_s.rp = AW'(s_ff.rp + 1'b1);
    end
    nxt_s.cnt = CW'(s_ff.cnt + CW'(do_wr) - CW'(do_rd));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule // usfp_fifo
`default_nettype wire

/* verilog/usfp_pkt.sv */
// packet commit tracker for one card-to-host endpoint
`timescale 1ns/1ps
`default_nettype none
module usfp_pkt #(
  parameter int PKT_WORDS = 256,
  parameter int CW = 9
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fifo events
  input wire logic push,
  input wire logic pop,
  input wire logic fifo_full,
  input wire logic commit_req,
  // packet state
  output logic avail,
  output logic last,
  output logic short_evt
);
  typedef struct packed {
    logic [CW-1:0] open_cnt;
    logic [CW-1:0] cmt_left;
    logic hold;
  } usfp_pkt_t;

  usfp_pkt_t s_ff;
  usfp_pkt_t nxt_s;
  logic [CW-1:0] open_next;
  logic commit;

  assign avail = (s_ff.cmt_left != '0);
  assign last = (s_ff.cmt_left == CW'(1));

  always_comb begin
    nxt_s = s_ff;
    short_evt = 1'b0;
    open_next = CW'(s_ff.open_cnt + CW'(push));
    // a full packet, or a fifo that can take no more, commits by itself
    commit = commit_req || (open_next == CW'(PKT_WORDS)) || fifo_full || s_ff.hold;
    if (pop && avail) begin
      nxt_s.cmt_left = CW'(s_ff.cmt_left - 1'b1);
    end
    nxt_s.open_cnt = open_next;
    // empty commits are dropped: no zero length packets
    if (commit && open_next != '0) begin
      if (nxt_s.cmt_left == '0) begin
        nxt_s.cmt_left = open_next;
        nxt_s.open_cnt = '0;
        nxt_s.hold = 1'b0;
        short_evt = (open_next < CW'(PKT_WORDS));
      end else begin
        nxt_s.hold = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule // usfp_pkt
`default_nettype wire

/* verif/usfp_port_assertions.sv */
// boundary checks for the slave fifo port
`timescale 1ns/1ps
`default_nettype none
module usfp_port_assertions #(
  parameter int PKT_WORDS = 256
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // card side
  input wire usfp_pkg::usfp_ctl_t ctl,
  input wire usfp_pkg::usfp_flags_t flags,
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  // usb side
  input wire logic usb_out_ready,
  input wire logic usb_in_ready,
  input wire logic usb_in_valid,
  input wire logic [15:0] usb_in_data,
  input wire logic usb_in_last,
  // register port
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  int unsigned words_ff;
  // packet length is counted, not unrolled, since it runs to hundreds
  always_ff @(posedge clk) begin
    if (!rst_n || (usb_in_valid && usb_in_ready && usb_in_last)) words_ff <= 0;
    else if (usb_in_valid && usb_in_ready) words_ff <= words_ff + 1;
  end
  a_pkt_bound: assert property (words_ff < PKT_WORDS)
    else $error("usb packet too long");
  a_reset_idle: assert property ($past(rst_n) == 1'b0 |->
    flags == 3'b010 && !usb_out_ready && !usb_in_valid)
    else $error("outputs not idle after reset");
  a_flags_excl: assert property (!(flags.full && flags.empty))
    else $error("full and empty together");
  a_oe_cause: assert property (data_oe |-> $past(ctl.oe_n) == 1'b0)
    else $error("bus driven without output enable");
  a_dout_cause: assert property ($changed(data_out) |-> $past(ctl.rd_n) == 1'b0)
    else $error("read data moved without strobe");
  a_in_hold: assert property (usb_in_valid && !usb_in_ready |=>
    usb_in_valid && $stable(usb_in_data) && $stable(usb_in_last))
    else $error("usb word dropped while stalled");
  a_last_valid: assert property (usb_in_last |-> usb_in_valid)
    else $error("packet end without word");
  a_rdata_gap: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
    else $error("read data outside read slot");
endmodule // usfp_port_assertions
`default_nettype wire

/* verif/usfp_card_model.sv */
// card fpga model driving the slave fifo port
`timescale 1ns/1ps
`default_nettype none
module usfp_card_model (
  // clock
  input wire logic clk,
  // port lines
  output logic [1:0] fifo_sel,
  output usfp_pkg::usfp_ctl_t ctl,
  output logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic data_oe
);
  logic drv;
  logic [15:0] wd;
  // wire level from both enables; a floating bus shows inverted data
  assign data_in = data_oe ? data_out : (drv ? wd : ~data_out);
  // sole owner, strobes released high when idle
  initial begin
    fifo_sel = 2'h0;
    ctl = 4'hF;
    drv = 1'b0;
    wd = 16'h0000;
  end
  task automatic pick(input logic [1:0] s);
    @(posedge clk);
    fifo_sel <= s;
    repeat (2) @(posedge clk);
  endtask
  // one word per strobe, packet end with the last
  task automatic wr(input logic [15:0] w, input logic e);
    @(posedge clk);
    ctl.wr_n <= 1'b0;
    ctl.pkt_end_n <= ~e;
    wd <= w;
    drv <= 1'b1;
    @(posedge clk);
    ctl <= 4'hF;
    drv <= 1'b0;
  endtask
  task automatic rd(output logic [15:0] w);
    @(posedge clk);
    ctl.oe_n <= 1'b0;
    ctl.rd_n <= 1'b0;
    @(posedge clk);
    ctl.rd_n <= 1'b1;
    @(posedge clk);
    w = data_out;
    ctl.oe_n <= 1'b1;
  endtask
endmodule // usfp_card_model
`default_nettype wire

/* verif/tb_usfp_port.sv */
// self-checking bench for the slave fifo port
`timescale 1ns/1ps
`default_nettype none
module tb_usfp_port;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic uo_v = 1'b0;
  logic [1:0] uo_ep = 2'h0;
  logic [15:0] uo_d = 16'h0000;
  logic [1:0] ui_ep = 2'h0;
  logic ui_rdy = 1'b0;
  logic [3:0] r_a = 4'h0;
  logic [15:0] r_wd = 16'h0000;
  logic r_wr = 1'b0;
  logic r_rd = 1'b0;
  logic [1:0] sel;
  usfp_pkg::usfp_ctl_t ctl;
  usfp_pkg::usfp_flags_t flags;
  logic [15:0] d_in, d_out, ui_d, rdata, v;
  logic d_oe, uo_rdy, ui_v, ui_last;
  int err_total = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  usfp_port uut (.clk(clk), .rst_n(rst_n), .fifo_sel(sel), .ctl(ctl), .flags(flags),
    .data_in(d_in), .data_out(d_out), .data_oe(d_oe), .usb_out_valid(uo_v),
    .usb_out_ep(uo_ep), .usb_out_data(uo_d), .usb_out_ready(uo_rdy), .usb_in_ep(ui_ep),
    .usb_in_ready(ui_rdy), .usb_in_valid(ui_v), .usb_in_data(ui_d), .usb_in_last(ui_last),
    .reg_addr(r_a), .reg_wdata(r_wd), .reg_wr(r_wr), .reg_rd(r_rd), .reg_rdata(rdata));
  usfp_card_model card (.clk(clk), .fifo_sel(sel), .ctl(ctl), .data_in(d_in),
    .data_out(d_out), .data_oe(d_oe));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_w(input logic [3:0] a, input logic [15:0] w);
    @(posedge clk);
    r_a <= a;
    r_wd <= w;
    r_wr <= 1'b1;
    @(posedge clk);
    r_wr <= 1'b0;
  endtask
  task automatic reg_r(input logic [3:0] a, output logic [15:0] w);
    @(posedge clk);
    r_a <= a;
    r_rd <= 1'b1;
    @(posedge clk);
    r_rd <= 1'b0;
    @(posedge clk);
    w = rdata;
  endtask
  task automatic usb_push(input logic [1:0] e, input logic [15:0] w);
    int n;
    @(posedge clk);
    uo_v <= 1'b1;
    uo_ep <= e;
    uo_d <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (uo_rdy !== 1'b1 && n < 50);
    uo_v <= 1'b0;
    if (n >= 50) begin
      err_total++;
      test_done();
    end
  endtask
  // the host polls, the stall toggles each cycle
  task automatic usb_pull(input logic [1:0] e, input int n, input logic [15:0] b);
    int k, t;
    ui_ep <= e;
    k = 0;
    t = 0;
    while (k < n && t < 200) begin
      @(posedge clk);
      t++;
      if (ui_v === 1'b1 && ui_rdy === 1'b1) begin
        chk(ui_d, b + 16'(k));
        chk(ui_last, k == n - 1);
        k++;
      end
      // one write per edge: the stall toggle also drops ready once done
      ui_rdy <= (k < n) && t[0];
    end
    if (k < n) begin
      err_total++;
      test_done();
    end
  endtask
  task automatic sc_regs();
    reg_r(usfp_pkg::REG_CTRL, v);
    chk(v, usfp_pkg::CTRL_RST);
    reg_r(usfp_pkg::REG_LEVEL, v);
    chk(v, usfp_pkg::LEVEL_RST);
    reg_r(usfp_pkg::REG_STATUS, v);
    chk(v, 16'h000F);
    reg_r(4'h2, v);
    chk(v, 16'h0000);
  endtask
  task automatic sc_out();
    for (int i = 0; i < 4; i++)
      usb_push(2'h0, 16'hA000 + 16'(i));
    card.pick(2'h0);
    chk(flags, 3'b001);
    for (int i = 0; i < 4; i++) begin
      card.rd(v);
      chk(v, 16'hA000 + 16'(i));
    end
    card.pick(2'h0);
    chk(flags, 3'b010);
    card.rd(v);
    chk(v, 16'hA003);
    card.wr(16'h1234, 1'b0);
    card.pick(2'h0);
    chk(flags, 3'b010);
  endtask
  task automatic sc_fill();
    card.pick(2'h2);
    for (int i = 0; i < 9; i++)
      card.wr(16'hB000 + 16'(i), 1'b0);
    card.pick(2'h2);
    chk(flags, 3'b101);
    reg_r(usfp_pkg::REG_STATUS, v);
    chk(v, 16'h004B);
    usb_pull(2'h2, 8, 16'hB000);
    card.pick(2'h2);
    chk(flags, 3'b010);
  endtask
  task automatic sc_short();
    reg_w(usfp_pkg::REG_SHORT, 16'h0000);
    card.pick(2'h3);
    for (int i = 0; i < 3; i++)
      card.wr(16'hC000 + 16'(i), i == 2);
    usb_pull(2'h3, 3, 16'hC000);
    reg_r(usfp_pkg::REG_SHORT, v);
    chk(v, 16'h0001);
  endtask
  // level threshold, direction change and bus enable on host-to-card fifos
  task automatic sc_level();
    reg_w(usfp_pkg::REG_LEVEL, 16'h0002);
    reg_r(usfp_pkg::REG_LEVEL, v);
    chk(v, 16'h0002);
    usb_push(2'h1, 16'hA100);
    usb_push(2'h1, 16'hA101);
    card.pick(2'h1);
    chk(flags, 3'b001);
    for (int i = 0; i < 2; i++) begin
      card.rd(v);
      chk(v, 16'hA100 + 16'(i));
      chk(d_oe, 1'b1);
    end
    reg_w(usfp_pkg::REG_CTRL, 16'h0004);
    reg_r(usfp_pkg::REG_CTRL, v);
    chk(v, 16'h0004);
    usb_push(2'h3, 16'hA300);
    card.pick(2'h3);
    chk(d_oe, 1'b0);
    card.rd(v);
    chk(v, 16'hA300);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    sc_regs();
    sc_out();
    sc_fill();
    sc_short();
    sc_level();
    test_done();
  end
endmodule // tb_usfp_port
bind usfp_port usfp_port_assertions #(.PKT_WORDS(PKT_WORDS)) chk_i (
  .clk(clk), .rst_n(rst_n), .ctl(ctl), .flags(flags), .data_out(data_out),
  .data_oe(data_oe), .usb_out_ready(usb_out_ready), .usb_in_ready(usb_in_ready),
  .usb_in_valid(usb_in_valid), .usb_in_data(usb_in_data), .usb_in_last(usb_in_last),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire
